// ---- rtl/sasl_pkg.sv ----
/*
 * Shared constants and types for the shared-line serial converter sampler.
 * Assumes a single 100 MHz system clock; all serial pins are asynchronous.
 */
package sasl_pkg;

   // Result width and code layout
   localparam int          RES_BITS     = 10;
   localparam logic [9:0]  SAR_FIRST    = 10'h200;
   localparam logic [9:0]  CODE_ZERO    = 10'h000;
   localparam logic [3:0]  MSB_IDX      = 4'h9;

   // Configuration word positions after the start bit (rising-edge count)
   localparam logic [3:0]  CFG_SGL_POS  = 4'h0;
   localparam logic [3:0]  CFG_POL_POS  = 4'h1;
   localparam logic [3:0]  CFG_DUM_POS  = 4'h2;

   // Falling edges after the start (or after chip select, fixed variant)
   // on which the hold begins and the data line is taken over
   localparam logic [3:0]  HOLD_FALL_MUX = 4'h4;
   localparam logic [3:0]  HOLD_FALL_FIX = 4'h2;

   // Rising-edge count in the output phase: 0 is the second null bit,
   // 1 .. 10 carry the result MSB first
   localparam logic [3:0]  OUT_FIRST    = 4'h1;
   localparam logic [3:0]  OUT_LAST     = 4'hA;

   // Analog selector encodings
   localparam logic [1:0]  SEL_CH0      = 2'h0;
   localparam logic [1:0]  SEL_CH1      = 2'h1;
   localparam logic [1:0]  SEL_GND      = 2'h2;

   typedef enum logic [2:0] {
      ST_SHUTDOWN,
      ST_HUNT,
      ST_CONFIG,
      ST_TRACK,
      ST_XFER
   } sasl_state_t;

endpackage

// ---- rtl/sasl_sar.sv ----
/*
 * Successive-approximation register for the 10-bit conversion.
 * Assumes i_comp is already synchronised and reflects the trial code
 * presented on o_trial well before each step request.
 */
`timescale 1ns/1ps

module sasl_sar
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Control
   input  wire logic       i_start,
   input  wire logic       i_step,
   input  wire logic       i_comp,
   // Status
   output logic [9:0]      o_trial,
   output logic            o_done
);

   logic [9:0] code;
   logic [3:0] idx;
   logic       busy;
   logic [9:0] next_code;
   logic [3:0] next_idx;
   logic       next_busy;
   logic       next_done;

   always_comb
   begin
      next_code = code;
      next_idx  = idx;
      next_busy = busy;
      next_done = 1'b0;
      if (i_start)
      begin
         next_code = sasl_pkg::SAR_FIRST;
         next_idx  = sasl_pkg::MSB_IDX;
         next_busy = 1'b1;
      end
      else if (i_step && busy)
      begin
         // Comparator high means input is at or above the trial: keep the bit
         next_code[idx] = i_comp;
         if (idx == 4'h0)
         begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
         else
         begin
            next_idx            = idx - 4'h1;
            next_code[idx-4'h1] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         code   <= sasl_pkg::CODE_ZERO;
         idx    <= 4'h0;
         busy   <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         code   <= next_code;
         idx    <= next_idx;
         busy   <= next_busy;
         o_done <= next_done;
      end
   end

   assign o_trial = code;

endmodule

// ---- rtl/sasl_top.sv ----
/*
 * Serial control and sequencing of a 10-bit SAR converter whose data input
 * and result output may share one wire. Holds the start-bit search,
 * configuration capture, sample window, hold, SAR stepping and result shift.
 * Assumes chip select, shift clock, data-in and comparator are asynchronous
 * pins, each far slower than the 100 MHz system clock.
 */
`timescale 1ns/1ps

module sasl_top
#(
   parameter bit MUXED = 1'b1
)
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Serial pins
   input  wire logic       i_cs_n,
   input  wire logic       i_sclk,
   input  wire logic       i_data_in,
   output logic            o_data_out,
   output logic            o_data_oe,
   // Analog front end
   input  wire logic       i_comp,
   output logic            o_powered,
   output logic            o_sample,
   output logic [1:0]      o_pos_sel,
   output logic [1:0]      o_neg_sel,
   output logic [9:0]      o_dac_trial,
   // Result
   output logic [9:0]      o_result,
   output logic            o_result_valid
);

   // Two-stage synchronisers; stage one is read only by stage two
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic       sclk_prev;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         sync1     <= 4'hF;
         sync2     <= 4'hF;
         sclk_prev <= 1'b1;
      end
      else
      begin
         sync1     <= {i_cs_n, i_sclk, i_data_in, i_comp};
         sync2     <= sync1;
         sclk_prev <= sync2[2];
      end
   end

   logic cs_n;
   logic din;
   logic comp;
   logic rise;
   logic fall;

   assign cs_n = sync2[3];
   assign din  = sync2[1];
   assign comp = sync2[0];
   assign rise = sync2[2] & ~sclk_prev;
   assign fall = ~sync2[2] & sclk_prev;

   // SAR engine
   logic       sar_start;
   logic       sar_step;
   logic [9:0] sar_trial;
   logic       sar_done;

   sasl_sar u_sar
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_start (sar_start),
      .i_step  (sar_step),
      .i_comp  (comp),
      .o_trial (sar_trial),
      .o_done  (sar_done)
   );

   sasl_pkg::sasl_state_t state;
   sasl_pkg::sasl_state_t next_state;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic       sgl;
   logic       next_sgl;
   logic       pol;
   logic       next_pol;
   logic       next_sample;
   logic       next_data_out;
   logic       next_data_oe;
   logic [1:0] next_pos_sel;
   logic [1:0] next_neg_sel;
   logic [9:0] next_result;
   logic       next_result_valid;

   always_comb
   begin
      next_state        = state;
      next_cnt          = cnt;
      next_sgl          = sgl;
      next_pol          = pol;
      next_sample       = o_sample;
      next_data_out     = o_data_out;
      next_data_oe      = o_data_oe;
      next_result       = o_result;
      next_result_valid = 1'b0;
      sar_start         = 1'b0;
      sar_step          = 1'b0;

      if (sar_done)
      begin
         next_result       = sar_trial;
         next_result_valid = 1'b1;
      end

      if (cs_n)
      begin
         // Deselected: abort, release the line, ignore clock and data
         next_state    = sasl_pkg::ST_SHUTDOWN;
         next_sample   = 1'b0;
         next_data_oe  = 1'b0;
         next_data_out = 1'b0;
         next_cnt      = 4'h0;
      end
      else
      begin
         case (state)
            sasl_pkg::ST_SHUTDOWN:
            begin
               next_cnt = 4'h0;
               if (MUXED)
                  next_state = sasl_pkg::ST_HUNT;
               else
               begin
                  // Fixed variant tracks from chip select fall
                  next_state  = sasl_pkg::ST_TRACK;
                  next_sample = 1'b1;
               end
            end
            sasl_pkg::ST_HUNT:
               if (rise && din)
               begin
                  next_state = sasl_pkg::ST_CONFIG;
                  next_cnt   = 4'h0;
               end
            sasl_pkg::ST_CONFIG:
               if (rise)
               begin
                  next_cnt = cnt + 4'h1;
                  if (cnt == sasl_pkg::CFG_SGL_POS)
                     next_sgl = din;
                  if (cnt == sasl_pkg::CFG_POL_POS)
                  begin
                     next_pol    = din;
                     next_sample = 1'b1;
                  end
                  if (cnt == sasl_pkg::CFG_DUM_POS)
                     next_state = sasl_pkg::ST_TRACK;
               end
            sasl_pkg::ST_TRACK:
               if (fall)
               begin
                  next_cnt = cnt + 4'h1;
                  // Mux variant: count already holds the three word rises
                  if ((MUXED && (cnt + 4'h1) == sasl_pkg::HOLD_FALL_MUX)
                      || (!MUXED && (cnt + 4'h1) == sasl_pkg::HOLD_FALL_FIX))
                  begin
                     next_state    = sasl_pkg::ST_XFER;
                     next_sample   = 1'b0;
                     sar_start     = 1'b1;
                     next_data_oe  = 1'b1;
                     next_data_out = 1'b0;
                     next_cnt      = 4'h0;
                  end
               end
            sasl_pkg::ST_XFER:
            begin
               if (fall)
                  sar_step = 1'b1;
               if (rise)
               begin
                  if (cnt != 4'hF)
                     next_cnt = cnt + 4'h1;
                  if (cnt >= sasl_pkg::OUT_FIRST && cnt <= sasl_pkg::OUT_LAST)
                     next_data_out = sar_trial[sasl_pkg::OUT_LAST - cnt];
                  else
                     next_data_out = 1'b0;
               end
            end
            default:
               next_state = sasl_pkg::ST_SHUTDOWN;
         endcase
      end
   end

   // Input pairing follows the mode and polarity bits; the fixed variant is CH0 against CH1 except in reset, which loads CH0 against ground
   always_comb
   begin
      if (!MUXED)
      begin
         next_pos_sel = sasl_pkg::SEL_CH0;
         next_neg_sel = sasl_pkg::SEL_CH1;
      end
      else if (next_sgl)
      begin
         next_pos_sel = next_pol ? sasl_pkg::SEL_CH1 : sasl_pkg::SEL_CH0;
         next_neg_sel = sasl_pkg::SEL_GND;
      end
      else
      begin
         next_pos_sel = next_pol ? sasl_pkg::SEL_CH1 : sasl_pkg::SEL_CH0;
         next_neg_sel = next_pol ? sasl_pkg::SEL_CH0 : sasl_pkg::SEL_CH1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state          <= sasl_pkg::ST_SHUTDOWN;
         cnt            <= 4'h0;
         sgl            <= 1'b1;
         pol            <= 1'b0;
         o_sample       <= 1'b0;
         o_data_out     <= 1'b0;
         o_data_oe      <= 1'b0;
         o_pos_sel      <= sasl_pkg::SEL_CH0;
         o_neg_sel      <= sasl_pkg::SEL_GND;
         o_result       <= sasl_pkg::CODE_ZERO;
         o_result_valid <= 1'b0;
         o_powered      <= 1'b0;
         o_dac_trial    <= sasl_pkg::CODE_ZERO;
      end
      else
      begin
         state          <= next_state;
         cnt            <= next_cnt;
         sgl            <= next_sgl;
         pol            <= next_pol;
         o_sample       <= next_sample;
         o_data_out     <= next_data_out;
         o_data_oe      <= next_data_oe;
         o_pos_sel      <= next_pos_sel;
         o_neg_sel      <= next_neg_sel;
         o_result       <= next_result;
         o_result_valid <= next_result_valid;
         o_powered      <= ~cs_n;
         o_dac_trial    <= sar_trial;
      end
   end

endmodule

// ---- testbench/sasl_host.sv ----
/* Host model on the shared data wire: frames, deselect and idle noise.
   Assumes the bench resolves the wire and feeds it back on i_line. */
`timescale 1ns/1ps
module sasl_host
(
   input  wire logic i_clk,
   input  wire logic i_line,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_drv,
   output logic      o_dout
);
   initial {o_cs_n, o_sclk, o_drv, o_dout} = 4'h8;
   task automatic half(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Bits launched while low, captured as the clock rises
   task automatic frame(input logic [15:0] bits, input int n_in, input int n_all,
                        output logic [11:0] got);
      got = 12'h000;
      o_cs_n = 1'b0;
      half(8);
      for (int i = 0; i < n_all; i++)
      begin
         o_drv = (i < n_in);
         o_dout = (i < n_in) ? bits[n_in-1-i] : 1'b0;
         half(8); // 160 ns shift period stays under the rate limit
         o_sclk = 1'b1;
         got = {got[10:0], i_line};
         half(4);
         // Let go mid-high so the takeover fall finds the wire free
         if (i == n_in - 1) o_drv = 1'b0;
         half(4);
         o_sclk = 1'b0;
      end
   endtask
   task automatic deselect();
      o_cs_n = 1'b1;
      o_drv = 1'b0;
      half(8);
   endtask
   task automatic noise();
      o_drv = 1'b1;
      repeat (6)
      begin
         o_sclk = ~o_sclk;
         o_dout = ~o_dout;
         half(4);
      end
      o_drv = 1'b0;
   endtask
endmodule

// ---- testbench/sasl_top_sva.sv ----
/* Timing checks on the serial pins of sasl_top.
   Assumes one 10 ns clock and host edges held for several clocks. */
`timescale 1ns/1ps
module sasl_top_sva
(
   // Clock and reset
   input wire logic       i_clk,
   input wire logic       i_rst,
   // Watched ports
   input wire logic       i_cs_n,
   input wire logic       i_sclk,
   input wire logic       o_data_out,
   input wire logic       o_data_oe,
   input wire logic       o_powered,
   input wire logic       o_sample,
   input wire logic [9:0] o_result,
   input wire logic       o_result_valid
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_idle;
      i_cs_n [*6];
   endsequence
   sequence s_active;
      !i_cs_n [*6];
   endsequence
   chk_idle_no_drive: assert property (s_idle |-> !o_data_oe && !o_powered)
      else $error("device active while deselected");
   chk_active_power: assert property (s_active |-> o_powered)
      else $error("no power while selected");
   chk_take_low: assert property ($rose(o_data_oe) |-> !o_data_out)
      else $error("takeover not low");
   chk_take_hold: assert property ($rose(o_data_oe) |-> $fell(o_sample))
      else $error("hold not with takeover");
   chk_valid_pulse: assert property (o_result_valid |=> !o_result_valid)
      else $error("valid longer than one cycle");
   chk_result_upd: assert property ($changed(o_result) |-> o_result_valid)
      else $error("result changed without valid");
   chk_valid_frame: assert property (o_result_valid |-> o_data_oe && o_powered)
      else $error("result outside a frame");
   chk_out_launch: assert property (o_data_oe && $past(o_data_oe) && $changed(o_data_out)
      |-> i_sclk && $past(i_sclk))
      else $error("output bit not launched after rise");
   chk_oe_release: assert property ($rose(i_cs_n) |-> ##[1:6] !o_data_oe)
      else $error("line not released on deselect");
endmodule

bind sasl_top sasl_top_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
   .i_sclk(i_sclk), .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_powered(o_powered),
   .o_sample(o_sample), .o_result(o_result), .o_result_valid(o_result_valid));

// ---- testbench/serial_adc_shared_line_sampler_test.sv ----
/* Self-checking bench for sasl_top, multiplexed and fixed variants.
   Assumes sasl_host as the far side and an ideal comparator model. */
`timescale 1ns/1ps
module serial_adc_shared_line_sampler_test;
   typedef struct {logic [1:0] cfg; int nz; logic [9:0] vin; logic [1:0] ep; logic [1:0] en;}
      sasl_row_t;
   localparam logic [1:0] C0 = sasl_pkg::SEL_CH0;
   localparam logic [1:0] C1 = sasl_pkg::SEL_CH1;
   localparam logic [1:0] GD = sasl_pkg::SEL_GND;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        cs_n, sclk, drv, hdo, comp;
   logic        flt = 1'b0;
   logic        fx_do, fx_oe, fx_comp;
   logic [1:0]  fx_pos, fx_neg;
   logic [9:0]  fx_dac, fx_res;
   logic [11:0] fx_got = 12'h000;
   logic        o_data_out, o_data_oe, o_powered, o_sample, o_result_valid;
   logic [1:0]  o_pos_sel, o_neg_sel;
   logic [9:0]  dac, o_result;
   logic [9:0]  vin = 10'h000;
   logic [11:0] got;
   wire         data_line;
   int          err_count = 0;
   int          n_tests = 0;
   sasl_row_t   rows [5] = '{'{2'b10, 0, 10'h000, C0, GD}, '{2'b11, 1, 10'h001, C1, GD},
      '{2'b00, 2, 10'h3FF, C0, C1}, '{2'b01, 3, 10'h3FE, C1, C0}, '{2'b10, 1, 10'h155, C0, GD}};
   always #5 i_clk = ~i_clk;
   // Undriven wire toggles so a stale level never reads as data
   assign data_line = o_data_oe ? o_data_out : (drv ? hdo : flt);
   always @(posedge i_clk) flt <= ~data_line;
   assign comp = (vin >= dac);
   always @(posedge i_clk)
      if (o_data_oe && drv)
      begin
         err_count++;
         $display("[FAIL] %0t two drivers on the wire", $time);
      end
   sasl_host u_host (.i_clk(i_clk), .i_line(data_line), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_drv(drv), .o_dout(hdo));
   sasl_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_data_in(data_line), .o_data_out(o_data_out), .o_data_oe(o_data_oe), .i_comp(comp),
      .o_powered(o_powered), .o_sample(o_sample), .o_pos_sel(o_pos_sel),
      .o_neg_sel(o_neg_sel), .o_dac_trial(dac), .o_result(o_result),
      .o_result_valid(o_result_valid));
   // Fixed variant shares chip select and clock but has a pin of its own
   sasl_top #(.MUXED(1'b0)) u_dut_fix (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_data_in(1'b0), .o_data_out(fx_do), .o_data_oe(fx_oe),
      .i_comp(fx_comp), .o_powered(), .o_sample(), .o_pos_sel(fx_pos), .o_neg_sel(fx_neg),
      .o_dac_trial(fx_dac), .o_result(fx_res), .o_result_valid());
   assign fx_comp = (vin >= fx_dac);
   // Released pin reads as ones so a missing takeover cannot pass as nulls
   always @(posedge sclk) fx_got <= {fx_got[10:0], fx_oe ? fx_do : 1'b1};
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #300000;
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end
   initial
   begin
      repeat (12) @(posedge i_clk);
      #1 i_rst = 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
      chk({10'h000, o_powered, o_data_oe}, 12'h000);
      $display("reset check done");
      foreach (rows[k])
      begin
         vin = rows[k].vin;
         u_host.frame({12'h000, 1'b1, rows[k].cfg, vin[0]}, rows[k].nz + 4, rows[k].nz + 16,
            got);
         chk(got, {2'b00, vin});
         chk({2'b00, o_result}, {2'b00, vin});
         chk({8'h00, o_pos_sel, o_neg_sel}, {8'h00, rows[k].ep, rows[k].en});
         u_host.deselect();
         chk({10'h000, o_powered, o_data_oe}, 12'h000);
         $display("frame %0d done", k);
      end
      vin = 10'h2AA;
      u_host.frame(16'h000E, 4, 3, got);
      chk({10'h000, o_sample, o_data_oe}, 12'h002);
      u_host.deselect();
      u_host.noise();
      chk({10'h000, o_powered, o_data_oe}, 12'h000);
      u_host.frame(16'h0008, 4, 16, got);
      chk(got, {2'b00, vin});
      u_host.deselect();
      $display("abort and idle noise done");
      vin = 10'h1C7;
      u_host.frame(16'h0000, 0, 14, got);
      chk(fx_got, {2'b00, vin});
      chk({2'b00, fx_res}, {2'b00, vin});
      chk({8'h00, fx_pos, fx_neg}, {8'h00, C0, C1});
      u_host.deselect();
      $display("fixed variant frame done");
      end_of_test();
   end
endmodule
